// ==== fsl_top.sv ====
// Purpose: Isolated four-wire synchronous serial link with AHB-Lite registers
// Assumes: Link clock comes from the far end and may stop between frames
// Notes:   Bytes cross domains by toggle handshakes
`timescale 1ns/100ps
// Function
// - Outgoing frame opens with zero start
// - No transmit start during receive frame
// - Outgoing byte shifted LSB first
// - Outgoing frame ends with zero flag
// - CTS drops next edge after start
// - Eight data bits received LSB first
// - Incoming flag bit is always zero
// - CTS low until receive buffer free
// - Mode 0x10 holds link in reset
// - Mode 0x00 releases link reset
// - Link runs only when configured serial
module fsl_top (
    input  wire logic        hclk,               // System clock
    input  wire logic        hresetn,            // Async reset, active low
    input  wire logic        hsel,               // Slave select
    input  wire logic [31:0] haddr,              // Address
    input  wire logic [1:0]  htrans,             // Transfer type
    input  wire logic        hwrite,             // Write strobe
    input  wire logic [2:0]  hsize,              // Size, word only
    input  wire logic [31:0] hwdata,             // Write data
    input  wire logic        hready,             // Bus ready
    output logic      [31:0] hrdata,             // Read data
    output logic             hreadyout,          // Slave ready
    output logic             hresp,              // Response, always OKAY
    input  wire logic        link_clock_in,      // Link clock from far end
    input  wire logic        serial_in_line,     // Serial data in
    output logic             serial_out_line,    // Serial data out
    output logic             clear_to_send_line  // Clear to send
);
    // ---------------- System domain ----------------
    fsl_pkg::fsl_req_t   req;          // Latched address phase
    logic                req_vld;      // Data phase pending
    logic [7:0]          mode;         // Mode byte
    logic                cfg_serial;   // Config selects serial mode
    logic [7:0]          tx_byte;      // Pending outgoing byte
    logic                tx_full;      // Outgoing byte pending
    logic                tx_req_t;     // Toggle: byte offered
    logic [7:0]          rx_byte;      // Received byte
    logic                rx_valid;     // Received byte waiting
    logic                rx_ack_t;     // Toggle: buffer freed
    logic [2:0]          tx_ack_s;     // Sync of link tx ack toggle
    logic [2:0]          rx_req_s;     // Sync of link rx toggle
    logic [1:0]          cts_s;        // Sync of cts for status
    logic                link_en;      // Link allowed to run
    // ---------------- Link domain ----------------
    fsl_pkg::fsl_state_t st;           // Link state
    logic [3:0]          bitn;         // Bit counter
    logic [7:0]          sh;           // Shift register
    logic                tx_ack_t;     // Toggle: byte sent
    logic                rx_req_t;     // Toggle: byte received
    logic [7:0]          rx_hold;      // Byte handed across
    logic [1:0]          txr_s;        // Sync of tx request toggle
    logic [1:0]          rxa_s;        // Sync of rx free toggle
    logic [1:0]          en_s;         // Sync of link enable
    logic                rx_busy;      // Buffer occupied, link view
    logic [1:0]          rst_l_s;      // Link reset release sync
    logic                in_q1, in_q2; // Serial input synchroniser

    logic acc_ok;
    assign acc_ok = hsel && hready && (htrans == fsl_pkg::HTRANS_NONSEQ);
    localparam logic [3:0] LAST_DATA = fsl_pkg::FLAG_IDX - 4'h1; // Counter value at the flag bit

    // Link enable held in one flop so the link domain never sees a decode glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) link_en <= 1'b0;
        else          link_en <= cfg_serial && (mode != fsl_pkg::MODE_RESET);
    end

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_vld <= 1'b0;
            req     <= '0;
        end else begin
            req_vld <= acc_ok;
            req     <= '{wr: hwrite, addr: haddr[7:0]};
        end
    end

    // Slave is always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read data registered in address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (acc_ok && !hwrite) begin
            case (haddr[7:0])
                fsl_pkg::REG_CTRL:   hrdata <= {23'h0, cfg_serial, mode};
                fsl_pkg::REG_STATUS: hrdata <= {28'h0, cts_s[1], !link_en, rx_valid, tx_full};
                fsl_pkg::REG_TXDATA: hrdata <= {24'h0, tx_byte};
                fsl_pkg::REG_RXDATA: hrdata <= {24'h0, rx_byte};
                default:             hrdata <= '0; // Unmapped reads zero
            endcase
        end
    end

    // Mode and configuration register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode       <= fsl_pkg::CTRL_RST;
            cfg_serial <= 1'b0;
        end else if (req_vld && req.wr && req.addr == fsl_pkg::REG_CTRL) begin
            mode       <= hwdata[fsl_pkg::CTRL_MODE_LO +: 8];
            cfg_serial <= hwdata[fsl_pkg::CTRL_CFG_BIT];
        end
    end

    // Handshake synchronisers, system side
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_ack_s <= '0;
            rx_req_s <= '0;
            cts_s    <= '0;
        end else begin
            tx_ack_s <= {tx_ack_s[1:0], tx_ack_t};
            rx_req_s <= {rx_req_s[1:0], rx_req_t};
            cts_s    <= {cts_s[0], clear_to_send_line};
        end
    end

    // Outgoing byte buffer; accepted even while link is held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_byte  <= '0;
            tx_full  <= 1'b0;
            tx_req_t <= 1'b0;
        end else if (tx_ack_s[2] != tx_ack_s[1]) begin
            tx_full <= 1'b0; // Byte left on the wire
        end else if (req_vld && req.wr && req.addr == fsl_pkg::REG_TXDATA && !tx_full) begin
            tx_byte  <= hwdata[7:0];
            tx_full  <= 1'b1;
            tx_req_t <= !tx_req_t;
        end
    end

    // Incoming byte buffer; reading frees room
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_byte  <= '0;
            rx_valid <= 1'b0;
            rx_ack_t <= 1'b0;
        end else if (rx_req_s[2] != rx_req_s[1]) begin
            rx_byte  <= rx_hold; // Stable since toggle
            rx_valid <= 1'b1;
        end else if (req_vld && !req.wr && req.addr == fsl_pkg::REG_RXDATA && rx_valid) begin
            rx_valid <= 1'b0;
            rx_ack_t <= !rx_ack_t;
        end
    end

    // Link reset release synchroniser
    always_ff @(posedge link_clock_in or negedge hresetn) begin
        if (!hresetn) rst_l_s <= '0;
        else          rst_l_s <= {rst_l_s[0], 1'b1};
    end

    // Link-side synchronisers; link clock is supplied by the far end
    always_ff @(posedge link_clock_in or negedge hresetn) begin
        if (!hresetn) begin
            txr_s <= '0;
            rxa_s <= '0;
            en_s  <= '0;
            in_q1 <= 1'b1;
            in_q2 <= 1'b1;
        end else begin
            txr_s <= {txr_s[0], tx_req_t};
            rxa_s <= {rxa_s[0], rx_ack_t};
            en_s  <= {en_s[0], link_en};
            in_q1 <= serial_in_line;
            in_q2 <= in_q1;
        end
    end

    logic tx_pend;
    assign tx_pend = (txr_s[1] != tx_ack_t);

    // Link framer: one bit per link clock edge
    always_ff @(posedge link_clock_in or negedge hresetn) begin
        if (!hresetn) begin
            st              <= fsl_pkg::FSL_IDLE;
            bitn            <= '0;
            sh              <= '0;
            serial_out_line <= 1'b1;
            tx_ack_t        <= 1'b0;
            rx_req_t        <= 1'b0;
            rx_hold         <= '0;
        end else if (!rst_l_s[1] || !en_s[1]) begin
            st              <= fsl_pkg::FSL_IDLE;
            serial_out_line <= 1'b1;
        end else begin
            case (st)
                fsl_pkg::FSL_IDLE: begin
                    bitn <= '0;
                    if (in_q2 == fsl_pkg::START_VAL && clear_to_send_line) begin
                        st <= fsl_pkg::FSL_RX; // receive wins
                    end else if (tx_pend) begin
                        serial_out_line <= fsl_pkg::START_VAL;
                        sh              <= tx_byte;            // Stable under handshake
                        st              <= fsl_pkg::FSL_TX;
                    end
                end
                fsl_pkg::FSL_TX: begin
                    bitn <= bitn + 4'h1;
                    if (bitn < LAST_DATA) begin
                        serial_out_line <= sh[0];
                        sh              <= {1'b0, sh[7:1]};
                    end else if (bitn == LAST_DATA) begin
                        serial_out_line <= fsl_pkg::FLAG_VAL;
                    end else begin
                        serial_out_line <= 1'b1;
                        tx_ack_t        <= !tx_ack_t;
                        st              <= fsl_pkg::FSL_IDLE;
                    end
                end
                fsl_pkg::FSL_RX: begin
                    bitn <= bitn + 4'h1;
                    if (bitn < LAST_DATA) begin
                        sh <= {in_q2, sh[7:1]};
                    end else begin
                        rx_hold  <= sh;          // Flag bit ignored
                        rx_req_t <= !rx_req_t;
                        st       <= fsl_pkg::FSL_IDLE;
                    end
                end
                default: st <= fsl_pkg::FSL_IDLE;
            endcase
        end
    end

    // Buffer occupancy as seen from the link
    always_ff @(posedge link_clock_in or negedge hresetn) begin
        if (!hresetn) rx_busy <= 1'b0;
        else          rx_busy <= (rx_req_t != rxa_s[1]);
    end

    // Clear-to-send: drops the edge after start, high only with room
    always_ff @(posedge link_clock_in or negedge hresetn) begin
        if (!hresetn) begin
            clear_to_send_line <= 1'b0;
        end else begin
            clear_to_send_line <= rst_l_s[1] && en_s[1] && !rx_busy &&
                                  (rx_req_t == rxa_s[1]) &&
                                  !(st == fsl_pkg::FSL_IDLE && in_q2 == fsl_pkg::START_VAL) &&
                                  (st != fsl_pkg::FSL_RX);
        end
    end

    // Assertions
    a_cts_drop: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        (st == fsl_pkg::FSL_IDLE && in_q2 == fsl_pkg::START_VAL && clear_to_send_line)
        |=> !clear_to_send_line)
        else $error("cts high after start");
    a_tx_start: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        $rose(st == fsl_pkg::FSL_TX) |-> !serial_out_line)
        else $error("start bit not zero");
    a_tx_flag: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        (st == fsl_pkg::FSL_TX && bitn == LAST_DATA) |=> !serial_out_line)
        else $error("source flag not zero");
    a_no_tx_rx: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        (st == fsl_pkg::FSL_IDLE && in_q2 == fsl_pkg::START_VAL && clear_to_send_line)
        |=> st != fsl_pkg::FSL_TX)
        else $error("transmit during receive");
    a_tx_len: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        $rose(st == fsl_pkg::FSL_TX) |-> (st == fsl_pkg::FSL_TX) [*8]
        ##1 (st == fsl_pkg::FSL_TX) ##1 (st == fsl_pkg::FSL_TX) ##1 (st != fsl_pkg::FSL_TX))
        else $error("tx frame length wrong");
    a_tx_lsb: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        $rose(st == fsl_pkg::FSL_TX) |=> serial_out_line == $past(sh[0]))
        else $error("first data bit not lsb");
    a_rx_cts: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        (st == fsl_pkg::FSL_RX) |-> ##1 !clear_to_send_line)
        else $error("cts high during receive");
    a_held_quiet: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        (!en_s[1]) |=> serial_out_line && !clear_to_send_line)
        else $error("link active while held");
    a_rx_handoff: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        (st == fsl_pkg::FSL_RX && bitn == LAST_DATA && rst_l_s[1] && en_s[1])
        |=> rx_req_t != $past(rx_req_t))
        else $error("received byte not handed over");
    a_cts_full: assert property (@(posedge link_clock_in) disable iff (!hresetn)
        (rx_req_t != rxa_s[1]) |=> !clear_to_send_line)
        else $error("cts high with buffer full");

    c_tx: cover property (@(posedge link_clock_in) disable iff (!hresetn) $rose(st == fsl_pkg::FSL_TX));
    c_rx: cover property (@(posedge link_clock_in) disable iff (!hresetn) $rose(st == fsl_pkg::FSL_RX));
    c_rd: cover property (@(posedge hclk) disable iff (!hresetn) rx_valid && req_vld);
    c_held: cover property (@(posedge link_clock_in) disable iff (!hresetn) !en_s[1] && tx_pend);
    c_cts_back: cover property (@(posedge link_clock_in) disable iff (!hresetn) $rose(clear_to_send_line));
endmodule : fsl_top

// ==== fsl_pkg.sv ====
// Purpose: Shared constants and types for the isolated serial link block
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes:   Register offsets are byte addresses
package fsl_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00; // Mode and configuration
    localparam logic [7:0] REG_STATUS = 8'h04; // Link state
    localparam logic [7:0] REG_TXDATA = 8'h08; // Outgoing byte
    localparam logic [7:0] REG_RXDATA = 8'h0C; // Incoming byte
    // Mode command values
    localparam logic [7:0] MODE_RESET = 8'h10; // Hold link in reset
    localparam logic [7:0] MODE_RUN   = 8'h00; // Release link
    // Control field positions
    localparam int CTRL_MODE_LO = 0;           // Mode byte low bit
    localparam int CTRL_CFG_BIT = 8;           // Serial mode selected by config
    // Status field positions
    localparam int ST_TX_FULL  = 0;            // Outgoing byte pending
    localparam int ST_RX_VALID = 1;            // Received byte waiting
    localparam int ST_LINK_RST = 2;            // Link held in reset
    localparam int ST_CTS      = 3;            // Clear-to-send level
    // Frame layout
    localparam logic [3:0] FRAME_BITS = 4'h9;  // Last bit index of ten-bit frame
    localparam logic [3:0] FLAG_IDX   = 4'h9;  // Flag bit position
    localparam logic       START_VAL  = 1'b0;  // Start bit value
    localparam logic       FLAG_VAL   = 1'b0;  // Source flag value
    localparam logic [7:0] CTRL_RST   = 8'h10; // Mode after reset: held
    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // Bus request carrier
    typedef struct packed {
        logic       wr;   // Write access
        logic [7:0] addr; // Byte offset
    } fsl_req_t;
    // Link states
    typedef enum logic [1:0] {FSL_IDLE, FSL_TX, FSL_RX} fsl_state_t;
endpackage : fsl_pkg

// ==== fsl_partner.sv ====
// Purpose: Far-end controller model that clocks the link and trades frames
// Assumes: Link clock period 30 ns; it toggles only while link_run is high
// Notes:   Drives and samples lines on falling link edges; idle line is pulled high
`timescale 1ns/100ps
module fsl_partner (
    input  wire logic       link_run,           // Let the link clock toggle
    input  wire logic       serial_out_line,    // Frames from the device
    input  wire logic       clear_to_send_line, // Device can take a byte
    output logic            link_clock_in,      // Link clock we source
    output logic            serial_in_line,     // Frames to the device
    output logic            rx_busy,            // Device frame in progress
    output logic      [7:0] got_byte,           // Last byte from the device
    output logic            got_flag,           // Its trailing flag bit
    output logic      [7:0] got_count,          // Device frames taken
    output logic      [7:0] err_count           // Device frames begun while we send
);
    logic [3:0] bit_idx; // Position within a device frame
    logic [7:0] shreg;   // Collected data bits
    logic       sending; // Our own frame is on the wire
    assign rx_busy = (bit_idx != 4'h0);
    // Clock source; stopping it is how we stall the device
    initial begin
        link_clock_in  = 1'b0;
        serial_in_line = 1'b1;
        sending        = 1'b0;
        bit_idx        = 4'h0;
        got_count      = 8'h00;
        err_count      = 8'h00;
        #7;
        forever begin
            #15;
            if (link_run) link_clock_in = ~link_clock_in;
        end
    end
    // Collect device frames: zero start, eight bits LSB first, then the flag
    always @(negedge link_clock_in) begin
        if (bit_idx == 4'h0) begin
            if (serial_out_line === 1'b0) begin // Start bit seen
                bit_idx <= 4'h1;
                if (sending) err_count <= err_count + 8'h01;
            end
        end else if (bit_idx < 4'h9) begin
            shreg   <= {serial_out_line, shreg[7:1]};
            bit_idx <= bit_idx + 4'h1;
        end else begin
            got_byte  <= shreg;
            got_flag  <= serial_out_line;
            got_count <= got_count + 8'h01;
            bit_idx   <= 4'h0;
        end
    end
    // Send one frame once the device is clear; ok low on timeout or late CTS
    task automatic send_frame(input logic [7:0] b, output logic ok);
        logic [9:0] fr;
        int         n;
        fr = {1'b0, b, 1'b0}; // Zero flag, data, zero start
        ok = 1'b0;
        for (n = 0; n < 400 && !ok; n++) begin
            @(negedge link_clock_in);
            ok = (clear_to_send_line === 1'b1) && (bit_idx == 4'h0);
        end
        sending = ok;
        for (n = 0; n < 10 && ok; n++) begin
            serial_in_line = fr[n]; // Data LSB first
            @(negedge link_clock_in);
            if (n == 9 && clear_to_send_line !== 1'b0) ok = 1'b0;
        end
        serial_in_line = 1'b1;
        sending = 1'b0;
    endtask : send_frame
endmodule : fsl_partner

// ==== fsl_top_tb.sv ====
// Purpose: Self-checking bench for the isolated serial link block
// Assumes: Zero-wait AHB-Lite slave; far-end model sources the link clock
// Notes:   Expected values come from the register map and the frame layout
`timescale 1ns/100ps
module fsl_top_tb;
    logic        hclk;       // System clock
    logic        hresetn;    // Reset, active low
    logic        hsel;       // Bus select
    logic [31:0] haddr;      // Bus address
    logic [1:0]  htrans;     // Transfer type
    logic        hwrite;     // Write access
    logic [2:0]  hsize;      // Transfer size
    logic [31:0] hwdata;     // Write data
    logic [31:0] hrdata;     // Read data
    logic        hreadyout;  // Slave ready, also the bus ready
    logic        hresp;      // Slave response
    logic        link_run;   // Far end lets its clock run
    logic        link_clk;   // Link clock
    logic        sin;        // Line into the device
    logic        sout;       // Line out of the device
    logic        cts;        // Clear to send
    logic        rx_busy;    // Far end taking a frame
    logic [7:0]  got_byte;   // Byte the far end took
    logic        got_flag;   // Flag bit the far end took
    logic [7:0]  got_count;  // Frames the far end took
    logic [7:0]  err_count;  // Frames begun during our send
    logic [31:0] q;          // Bus read result
    logic        ok;         // Far-end send result
    int          n_mismatch; // Mismatches
    int          checks;     // Comparisons
    int          n;          // Loop count
    fsl_top fsl_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link_clock_in(link_clk), .serial_in_line(sin), .serial_out_line(sout),
        .clear_to_send_line(cts));
    fsl_partner fsl_partner_inst (.link_run(link_run), .serial_out_line(sout),
        .clear_to_send_line(cts), .link_clock_in(link_clk), .serial_in_line(sin),
        .rx_busy(rx_busy), .got_byte(got_byte), .got_flag(got_flag),
        .got_count(got_count), .err_count(err_count));
    // System clock, 10 ns period
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Counts and verdict, then stop
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // Compare one value and report a difference
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Wait for a ready edge; give up after a bound
    task automatic rdy;
        for (n = 0; n < 20; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (n == 20) begin
            n_mismatch++;
            final_report;
        end
    endtask : rdy
    // One single-word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= fsl_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        rdy;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask : bus
    // Wait for the far end to hold k frames
    task automatic wait_got(input logic [7:0] k);
        for (n = 0; n < 3000 && got_count !== k; n++) @(posedge hclk);
        if (got_count !== k) begin
            n_mismatch++;
            final_report;
        end
    endtask : wait_got
    // Poll status until the outgoing buffer is free; give up after a bound
    task automatic wait_tx_free;
        int i;
        for (i = 0; i < 50; i++) begin
            bus(1'b0, fsl_pkg::REG_STATUS, 32'h0);
            if (q[fsl_pkg::ST_TX_FULL] === 1'b0) break;
        end
        if (i == 50) begin
            n_mismatch++;
            final_report;
        end
    endtask : wait_tx_free
    // Main sequence
    initial begin
        hresetn  = 1'b0;
        hsel     = 1'b0;
        haddr    = 32'h00000000;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hsize    = 3'h2;
        hwdata   = 32'h00000000;
        link_run = 1'b1;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("ready", hreadyout, 32'h1);
        check("resp", hresp, 32'h0);
        check("idle out", sout, 32'h1);
        bus(1'b0, fsl_pkg::REG_CTRL, 32'h0);
        check("ctrl reset", q, 32'h10);
        bus(1'b0, fsl_pkg::REG_STATUS, 32'h0);
        check("status reset", q & 32'hF, 32'h4);
        bus(1'b1, 8'h10, 32'hFF);
        bus(1'b0, 8'h10, 32'h0);
        check("unmapped", q, 32'h0);
        $display("test reset done");
        bus(1'b1, fsl_pkg::REG_TXDATA, 32'hA5);
        bus(1'b1, fsl_pkg::REG_CTRL, 32'h110);
        repeat (300) @(posedge hclk);
        check("frames held", got_count, 32'h0);
        bus(1'b1, fsl_pkg::REG_CTRL, 32'h0);
        repeat (300) @(posedge hclk);
        check("frames unconfigured", got_count, 32'h0);
        bus(1'b0, fsl_pkg::REG_STATUS, 32'h0);
        check("tx pending", q[fsl_pkg::ST_TX_FULL], 32'h1);
        check("held flag", q[fsl_pkg::ST_LINK_RST], 32'h1);
        bus(1'b1, fsl_pkg::REG_CTRL, 32'h100);
        wait_got(8'h01);
        check("tx byte", got_byte, 32'hA5);
        check("tx flag", got_flag, 32'h0);
        $display("test hold and release done");
        wait_tx_free;
        bus(1'b1, fsl_pkg::REG_TXDATA, 32'h3C);
        for (n = 0; n < 500 && rx_busy !== 1'b1; n++) @(posedge hclk);
        if (rx_busy !== 1'b1) begin
            n_mismatch++;
            final_report;
        end
        link_run <= 1'b0;
        repeat (200) @(posedge hclk);
        link_run <= 1'b1;
        wait_got(8'h02);
        check("stalled byte", got_byte, 32'h3C);
        $display("test stall done");
        fork
            fsl_partner_inst.send_frame(8'h5A, ok);
            begin
                repeat (10) @(posedge hclk);
                bus(1'b1, fsl_pkg::REG_TXDATA, 32'h81);
            end
        join
        check("tx waits", got_count, 32'h2);
        check("cts drop", ok, 32'h1);
        repeat (100) @(posedge hclk);
        check("cts held", cts, 32'h0);
        check("no tx in rx", err_count, 32'h0);
        bus(1'b0, fsl_pkg::REG_STATUS, 32'h0);
        check("rx valid", q[fsl_pkg::ST_RX_VALID], 32'h1);
        bus(1'b0, fsl_pkg::REG_RXDATA, 32'h0);
        check("rx byte", q & 32'hFF, 32'h5A);
        wait_got(8'h03);
        check("tx after rx", got_byte, 32'h81);
        for (n = 0; n < 500 && cts !== 1'b1; n++) @(posedge hclk);
        check("cts back", cts, 32'h1);
        $display("test receive done");
        final_report;
    end
endmodule : fsl_top_tb
